// File: oas_pkg.sv
// Purpose: shared constants and carriers of the operand addressing decoder
// Assumes: 8-bit opcodes, 16-bit program addresses
// Notes:   offsets and some field positions live here; the opcode bit fields are coded in the decoder
package oas_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0]  STATUS_OFS     = 8'h00;
    localparam logic [7:0]  STATUS_RESET   = 8'h00;
    localparam logic [7:0]  STATUS_WR_MASK = 8'hFE;
    localparam logic [7:0]  CARRY_MASK     = 8'h80;
    localparam int          BS_HI_POS      = 4;
    localparam int          BS_LO_POS      = 3;

    ////////////////////////////////////////////////////////////////////////
    // opcodes and opcode fields
    localparam logic [7:0]  OPC_NO_OP      = 8'h00;
    localparam logic [7:0]  OPC_UNUSED     = 8'hA5;
    localparam logic [7:0]  OPC_SHORT_JUMP = 8'h80;
    localparam logic [7:0]  OPC_LONG_JUMP  = 8'h02;
    localparam logic [7:0]  OPC_LONG_CALL  = 8'h12;
    localparam logic [7:0]  OPC_BIT_CLR_JP = 8'h10;
    localparam logic [7:0]  OPC_BIT_SET_JP = 8'h20;
    localparam logic [7:0]  OPC_BIT_NOT_JP = 8'h30;
    localparam logic [7:0]  OPC_CARRY_JP   = 8'h40;
    localparam logic [7:0]  OPC_NCARRY_JP  = 8'h50;
    localparam logic [7:0]  OPC_ZERO_JP    = 8'h60;
    localparam logic [7:0]  OPC_NZERO_JP   = 8'h70;
    localparam logic [7:0]  OPC_DEC_DIR_JP = 8'hD5;
    localparam logic [7:0]  OPC_CMP_LO     = 8'hB4;
    localparam logic [7:0]  OPC_CMP_HI     = 8'hBF;
    localparam logic [4:0]  OPC_DEC_REG_JP = 5'h1B;
    localparam logic [3:0]  PAGE_OPC_LOW   = 4'h1;
    localparam logic [3:0]  DIRECT_OPC_LOW = 4'h5;
    localparam logic [2:0]  INDIR_OPC_MID  = 3'h3;

    ////////////////////////////////////////////////////////////////////////
    // address spaces
    localparam int          PAGE_BITS      = 11;
    localparam int          HIGH_SPACE_BIT = 7;
    localparam logic [15:0] PROG_MEM_BYTES = 16'h1E00;

    typedef enum logic [2:0] {
        K_NONE     = 3'h0,
        K_BANK_REG = 3'h1,
        K_INDIRECT = 3'h2,
        K_DIRECT   = 3'h3,
        K_REL      = 3'h4,
        K_PAGE     = 3'h5,
        K_FULL     = 3'h6,
        K_NOP      = 3'h7
    } oas_kind_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_WAIT  = 2'b11
    } oas_state_e;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  op1;
        logic [7:0]  op2;
        logic [15:0] next_pc;
    } oas_instr_s;

    typedef struct packed {
        logic        valid;
        oas_kind_e   kind;
        logic        ram_access;
        logic        spc_access;
        logic [7:0]  data_addr;
        logic        target_valid;
        logic        target_in_range;
        logic [15:0] target;
        logic        advance_only;
    } oas_result_s;

endpackage

// File: oas_psw.sv
// Purpose: program status word with carry, bank select and parity
// Assumes: alu_valid marks one arithmetic result per cycle
// Notes:   hardware carry update wins over a software write
`timescale 1ns/1ns
`default_nettype none
module oas_status_word
    import oas_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    input  wire logic       alu_valid,
    input  wire logic       alu_carry,
    input  wire logic [7:0] accumulator,
    output logic      [7:0] status_word,
    output logic      [1:0] bank_sel
);

    logic [7:0] status_q;
    logic [7:0] base_d;
    logic [7:0] status_d;

    // bit 0 never stored; writes to it are dropped
    assign base_d      = wr_en ? (wdata & STATUS_WR_MASK) : status_q;
    assign status_d    = alu_valid ? ((base_d & ~CARRY_MASK) | (alu_carry ? CARRY_MASK : 8'h00))
                                   : base_d;
    assign status_word = {status_q[7:1], ^accumulator};
    assign bank_sel    = status_q[BS_HI_POS:BS_LO_POS];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_carry;
        @(posedge core_clk) disable iff (!rst_n)
        alu_valid |=> (status_word[7] == $past(alu_carry));
    endproperty
    a_carry: assert property (p_carry) else $error("carry not following alu");

    property p_parity;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_en && wdata[0]) |=> (status_q[0] == 1'b0) && (status_word[0] == ^accumulator);
    endproperty
    a_parity: assert property (p_parity) else $error("parity bit writable");

    property p_bank;
        @(posedge core_clk) disable iff (!rst_n)
        wr_en |=> (bank_sel == $past(wdata[BS_HI_POS:BS_LO_POS]));
    endproperty
    a_bank: assert property (p_bank) else $error("bank select not written");

endmodule
`default_nettype wire

// File: oas_decoder.sv
// Purpose: operand addressing and branch target decoder with status word
// Assumes: ram_rdata answers one cycle after ram_rd_q
// Notes:   one request at a time; dec_ready_q low while a pointer is fetched
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
module oas_decoder
    import oas_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata_q,
    input  wire oas_instr_s  dec_req,
    input  wire logic        dec_valid,
    output logic             dec_ready_q,
    output oas_result_s      dec_res_q,
    input  wire logic [7:0]  accumulator,
    input  wire logic        alu_valid,
    input  wire logic        alu_carry,
    output logic             ram_rd_q,
    output logic      [7:0]  ram_addr_q,
    input  wire logic [7:0]  ram_rdata
);

    ////////////////////////////////////////////////////////////////////////
    // status word and register port
    logic [7:0]  status_word;
    logic [1:0]  bank_sel;
    logic        status_hit;
    logic [7:0]  rdata_d;

    assign status_hit = (reg_addr == STATUS_OFS);
    assign rdata_d    = (reg_rd && status_hit) ? status_word : 8'h00;

    oas_status_word u_status (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .wr_en       (reg_wr && status_hit),
        .wdata       (reg_wdata),
        .alu_valid   (alu_valid),
        .alu_carry   (alu_carry),
        .accumulator (accumulator),
        .status_word (status_word),
        .bank_sel    (bank_sel)
    );

    ////////////////////////////////////////////////////////////////////////
    // opcode classes
    logic [7:0]  opc;
    logic [7:0]  op1;
    logic [7:0]  op2;
    logic [15:0] next_pc;
    logic        is_nop;
    logic        is_page;
    logic        is_full;
    logic        rel2;
    logic        rel3;
    logic        is_rel;
    logic        is_indir;
    logic        is_bank;
    logic        is_direct;

    assign opc     = dec_req.opcode;
    assign op1     = dec_req.op1;
    assign op2     = dec_req.op2;
    assign next_pc = dec_req.next_pc;

    assign is_nop    = (opc == OPC_NO_OP) || (opc == OPC_UNUSED);
    assign is_page   = (opc[3:0] == PAGE_OPC_LOW);
    assign is_full   = (opc == OPC_LONG_JUMP) || (opc == OPC_LONG_CALL);
    assign rel2      = (opc == OPC_SHORT_JUMP) || (opc == OPC_CARRY_JP)
                    || (opc == OPC_NCARRY_JP) || (opc == OPC_ZERO_JP)
                    || (opc == OPC_NZERO_JP) || (opc[7:3] == OPC_DEC_REG_JP);
    assign rel3      = (opc == OPC_BIT_CLR_JP) || (opc == OPC_BIT_SET_JP)
                    || (opc == OPC_BIT_NOT_JP) || (opc == OPC_DEC_DIR_JP)
                    || ((opc >= OPC_CMP_LO) && (opc <= OPC_CMP_HI));
    assign is_rel    = rel2 || rel3;
    assign is_indir  = (opc[3:1] == INDIR_OPC_MID);
    assign is_bank   = opc[3];
    assign is_direct = (opc[3:0] == DIRECT_OPC_LOW) && !is_nop;

    ////////////////////////////////////////////////////////////////////////
    // operand addresses
    logic [7:0]  bank_addr;
    logic [7:0]  ptr_addr;
    logic [7:0]  data_addr;
    logic        to_special;

    assign bank_addr = {3'b000, bank_sel, opc[2:0]};
    assign ptr_addr  = {3'b000, bank_sel, 2'b00, opc[0]};
    assign to_special = op1[HIGH_SPACE_BIT];
    assign data_addr = is_bank ? bank_addr : (is_direct ? op1 : 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // branch targets
    logic [7:0]  disp;
    logic [15:0] rel_tgt;
    logic [15:0] page_tgt;
    logic [15:0] full_tgt;
    logic [15:0] tgt;
    logic        tgt_valid;

    assign disp      = rel3 ? op2 : op1;
    assign rel_tgt   = next_pc + {{8{disp[7]}}, disp};
    assign page_tgt  = {next_pc[15:PAGE_BITS], opc[7:5], op1};
    assign full_tgt  = {op1, op2};
    assign tgt_valid = is_page || is_full || is_rel;
    assign tgt       = is_page ? page_tgt : (is_full ? full_tgt : (is_rel ? rel_tgt : 16'h0000));

    ////////////////////////////////////////////////////////////////////////
    // result assembly
    oas_kind_e   kind;
    oas_result_s res_now;
    oas_result_s ind_res;

    assign kind = is_nop    ? K_NOP :
                  is_page   ? K_PAGE :
                  is_full   ? K_FULL :
                  is_rel    ? K_REL :
                  is_indir  ? K_INDIRECT :
                  is_bank   ? K_BANK_REG :
                  is_direct ? K_DIRECT : K_NONE;

    // no-operation forms leave every access and target off
    assign res_now = '{
        valid:           1'b1,
        kind:            kind,
        ram_access:      is_bank || is_indir || (is_direct && !to_special),
        spc_access:      is_direct && to_special,
        data_addr:       data_addr,
        target_valid:    tgt_valid,
        target_in_range: tgt_valid && (tgt < PROG_MEM_BYTES),
        target:          tgt,
        advance_only:    is_nop
    };

    ////////////////////////////////////////////////////////////////////////
    // pointer fetch sequence
    oas_state_e  state_q;
    oas_state_e  state_d;
    oas_result_s hold_q;
    logic        take;

    assign take = dec_valid && (state_q == ST_IDLE);

    always_comb begin
        unique case (state_q)
            ST_IDLE:  state_d = (take && is_indir) ? ST_FETCH : ST_IDLE;
            ST_FETCH: state_d = ST_WAIT;
            ST_WAIT:  state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    // pointer contents become the RAM location
    assign ind_res = '{
        valid:           1'b1,
        kind:            hold_q.kind,
        ram_access:      1'b1,
        spc_access:      1'b0,
        data_addr:       ram_rdata,
        target_valid:    hold_q.target_valid,
        target_in_range: hold_q.target_in_range,
        target:          hold_q.target,
        advance_only:    1'b0
    };

    oas_result_s res_d;
    oas_result_s hold_d;
    logic        rd_d;
    logic [7:0]  raddr_d;

    assign res_d   = (take && !is_indir) ? res_now : ((state_q == ST_WAIT) ? ind_res : '0);
    assign hold_d  = take ? res_now : hold_q;
    assign rd_d    = take && is_indir;
    assign raddr_d = rd_d ? ptr_addr : 8'h00;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q     <= ST_IDLE;
            dec_ready_q <= 1'b1;
            dec_res_q   <= '0;
            hold_q      <= '0;
            ram_rd_q    <= 1'b0;
            ram_addr_q  <= 8'h00;
            reg_rdata_q <= 8'h00;
        end else begin
            state_q     <= state_d;
            dec_ready_q <= (state_d == ST_IDLE);
            dec_res_q   <= res_d;
            hold_q      <= hold_d;
            ram_rd_q    <= rd_d;
            ram_addr_q  <= raddr_d;
            reg_rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_bank_reg;
        (take && is_bank && !is_indir) |=>
            dec_res_q.valid && dec_res_q.ram_access
            && (dec_res_q.data_addr == {3'b000, $past(bank_sel), $past(opc[2:0])});
    endproperty
    a_bank_reg: assert property (p_bank_reg) else $error("bank register address wrong");

    sequence s_ptr_issue;
        ram_rd_q && !dec_res_q.valid
        && (ram_addr_q == {3'b000, $past(bank_sel), 2'b00, $past(opc[0])});
    endsequence

    sequence s_ptr_result;
        dec_res_q.valid && dec_res_q.ram_access
        && (dec_res_q.data_addr == $past(ram_rdata));
    endsequence

    property p_indirect;
        (take && is_indir) |=> s_ptr_issue ##1 (!dec_res_q.valid && !ram_rd_q) ##1 s_ptr_result;
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect pointer sequence wrong");

    property p_rel;
        (take && (opc == OPC_SHORT_JUMP)) |=>
            dec_res_q.target_valid && (dec_res_q.kind == K_REL)
            && (dec_res_q.target == $past(next_pc) + {{8{$past(op1[7])}}, $past(op1)});
    endproperty
    a_rel: assert property (p_rel) else $error("short jump target wrong");

    property p_rel_cond;
        (take && rel3 && !is_indir) |=>
            dec_res_q.target_valid
            && (dec_res_q.target == $past(next_pc) + {{8{$past(op2[7])}}, $past(op2)});
    endproperty
    a_rel_cond: assert property (p_rel_cond) else $error("conditional jump target wrong");

    property p_rel_op1;
        (take && rel2) |=>
            dec_res_q.target_valid && (dec_res_q.kind == K_REL)
            && (dec_res_q.target == $past(next_pc) + {{8{$past(op1[7])}}, $past(op1)});
    endproperty
    a_rel_op1: assert property (p_rel_op1) else $error("two-byte jump target wrong");

    sequence s_busy_gap;
        !dec_ready_q ##1 !dec_ready_q;
    endsequence

    property p_busy;
        (take && is_indir) |=> s_busy_gap ##1 dec_ready_q;
    endproperty
    a_busy: assert property (p_busy) else $error("ready not low during pointer fetch");

    property p_direct;
        (take && is_direct) |=>
            (dec_res_q.data_addr == $past(op1))
            && (dec_res_q.spc_access == $past(op1[7]))
            && (dec_res_q.ram_access == !$past(op1[7]));
    endproperty
    a_direct: assert property (p_direct) else $error("direct address routed wrong");

    property p_page_field;
        (take && is_page) |=>
            dec_res_q.target_valid && (dec_res_q.target[10:0] == {$past(opc[7:5]), $past(op1)});
    endproperty
    a_page_field: assert property (p_page_field) else $error("page field wrong");

    property p_page;
        (take && is_page) |=> (dec_res_q.target[15:11] == $past(next_pc[15:11]));
    endproperty
    a_page: assert property (p_page) else $error("page not kept");

    property p_full;
        (take && is_full) |=> (dec_res_q.kind == K_FULL) && (dec_res_q.target == {$past(op1), $past(op2)});
    endproperty
    a_full: assert property (p_full) else $error("long target wrong");

    property p_range;
        (take && is_full) |=> (dec_res_q.target_in_range == ($past(full_tgt) < PROG_MEM_BYTES));
    endproperty
    a_range: assert property (p_range) else $error("long target range flag wrong");

    property p_nop;
        (take && (opc == OPC_UNUSED)) |=>
            dec_res_q.valid && dec_res_q.advance_only && (dec_res_q.kind == K_NOP)
            && !dec_res_q.ram_access && !dec_res_q.spc_access && !dec_res_q.target_valid
            && !ram_rd_q && dec_ready_q;
    endproperty
    a_nop: assert property (p_nop) else $error("unused opcode not a no-operation");

endmodule
`default_nettype wire

// File: oas_decoder_tb_top.sv
// Purpose: self-checking bench of the operand addressing decoder and status word
// Assumes: pointer bytes answer one cycle after a pointer read, as a scrambled address
// Notes:   table rows run back to back; status word and pointer fetch are tested by hand
`timescale 1ns/1ns
`default_nettype none
module oas_decoder_tb_top
    import oas_pkg::*;
;
    typedef struct packed {
        oas_instr_s  req;
        oas_result_s exp;
    } oas_row_s;

    logic        core_clk;
    logic        rst_n;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata_q;
    oas_instr_s  dec_req;
    logic        dec_valid;
    logic        dec_ready_q;
    oas_result_s dec_res_q;
    logic [7:0]  accumulator;
    logic        alu_valid;
    logic        alu_carry;
    logic        ram_rd_q;
    logic [7:0]  ram_addr_q;
    logic [7:0]  ram_rdata;
    oas_row_s    rows [19];
    int          n_fail;
    int          num_checks;

    oas_decoder i_dut (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata_q (reg_rdata_q),
        .dec_req     (dec_req),
        .dec_valid   (dec_valid),
        .dec_ready_q (dec_ready_q),
        .dec_res_q   (dec_res_q),
        .accumulator (accumulator),
        .alu_valid   (alu_valid),
        .alu_carry   (alu_carry),
        .ram_rd_q    (ram_rd_q),
        .ram_addr_q  (ram_addr_q),
        .ram_rdata   (ram_rdata)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // pointer bytes: valid only in the answer cycle, toggling otherwise
    always @(posedge core_clk) begin
        ram_rdata <= ram_rd_q ? (ram_addr_q ^ 8'h4B) : ~ram_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d, input logic alu, input logic c);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        alu_valid <= alu;
        alu_carry <= c;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        alu_valid <= 1'b0;
    endtask

    task automatic alu_event(input logic c);
        @(posedge core_clk);
        alu_valid <= 1'b1;
        alu_carry <= c;
        @(posedge core_clk);
        alu_valid <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(64'(reg_rdata_q), 64'(exp));
        @(negedge core_clk);
        check(64'(reg_rdata_q), 64'h0);
    endtask

    function automatic oas_row_s mk(logic [7:0] opc, logic [7:0] o1, logic [7:0] o2, logic [15:0] pc,
                                    oas_kind_e k, logic ram, logic spc, logic [7:0] da, logic [15:0] tg);
        logic     tv;
        oas_row_s r;
        tv = (k == K_REL) || (k == K_PAGE) || (k == K_FULL);
        r.req = '{opcode: opc, op1: o1, op2: o2, next_pc: pc};
        r.exp = '{valid: 1'b1, kind: k, ram_access: ram, spc_access: spc, data_addr: da,
                  target_valid: tv, target_in_range: tv && (tg < PROG_MEM_BYTES),
                  target: tg, advance_only: (k == K_NOP)};
        return r;
    endfunction

    // pointer fetch through register ri of bank bk, with a refused request while busy
    task automatic indirect(input logic [1:0] bk, input logic ri);
        logic [7:0]  pa;
        oas_result_s e;
        pa = {3'h0, bk, 2'h0, ri};
        e = '0;
        e.valid = 1'b1;
        e.kind = K_INDIRECT;
        e.ram_access = 1'b1;
        e.data_addr = pa ^ 8'h4B;
        reg_write(STATUS_OFS, {3'h0, bk, 3'h0}, 1'b0, 1'b0);
        @(posedge core_clk);
        dec_req   <= '{opcode: {7'h73, ri}, op1: 8'h00, op2: 8'h00, next_pc: 16'h0100};
        dec_valid <= 1'b1;
        @(posedge core_clk);
        dec_req <= '{opcode: OPC_UNUSED, op1: 8'h00, op2: 8'h00, next_pc: 16'h0200};
        @(negedge core_clk);
        check(64'({ram_rd_q, ram_addr_q, dec_ready_q}), 64'({1'b1, pa, 1'b0}));
        @(posedge core_clk);
        dec_valid <= 1'b0;
        @(negedge core_clk);
        check(64'({ram_rd_q, dec_ready_q, dec_res_q.valid}), 64'h0);
        @(negedge core_clk);
        check(64'(dec_res_q), 64'(e));
        check(64'(dec_ready_q), 64'h1);
        @(negedge core_clk);
        check(64'(dec_res_q), 64'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (3000) @(posedge core_clk);
        n_fail++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        n_fail = 0;
        num_checks = 0;
        rst_n = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, accumulator, alu_valid, alu_carry} = '0;
        dec_req = '0;
        dec_valid = 1'b0;
        ram_rdata = 8'h00;
        rows[0]  = mk(8'hE5, 8'h30, 8'h00, 16'h0102, K_DIRECT, 1'b1, 1'b0, 8'h30, 16'h0000);
        rows[1]  = mk(8'hE5, 8'h7F, 8'h00, 16'h0102, K_DIRECT, 1'b1, 1'b0, 8'h7F, 16'h0000);
        rows[2]  = mk(8'hF5, 8'h80, 8'h00, 16'h0102, K_DIRECT, 1'b0, 1'b1, 8'h80, 16'h0000);
        rows[3]  = mk(8'hE8, 8'h00, 8'h00, 16'h0102, K_BANK_REG, 1'b1, 1'b0, 8'h10, 16'h0000);
        rows[4]  = mk(8'hFF, 8'h00, 8'h00, 16'h0102, K_BANK_REG, 1'b1, 1'b0, 8'h17, 16'h0000);
        rows[5]  = mk(OPC_SHORT_JUMP, 8'hFE, 8'h00, 16'h0102, K_REL, 1'b0, 1'b0, 8'h00, 16'h0100);
        rows[6]  = mk(OPC_CARRY_JP, 8'h7F, 8'h00, 16'h0010, K_REL, 1'b0, 1'b0, 8'h00, 16'h008F);
        rows[7]  = mk(OPC_NCARRY_JP, 8'h80, 8'h00, 16'h0100, K_REL, 1'b0, 1'b0, 8'h00, 16'h0080);
        rows[8]  = mk(OPC_ZERO_JP, 8'h00, 8'h00, 16'h1DFE, K_REL, 1'b0, 1'b0, 8'h00, 16'h1DFE);
        rows[9]  = mk(OPC_NZERO_JP, 8'hFF, 8'h00, 16'h0000, K_REL, 1'b0, 1'b0, 8'h00, 16'hFFFF);
        rows[10] = mk(OPC_CMP_LO, 8'h55, 8'h02, 16'h0200, K_REL, 1'b0, 1'b0, 8'h00, 16'h0202);
        rows[11] = mk(8'hE1, 8'h23, 8'h00, 16'h37FE, K_PAGE, 1'b0, 1'b0, 8'h00, 16'h3723);
        rows[12] = mk(8'h11, 8'hFF, 8'h00, 16'h0800, K_PAGE, 1'b0, 1'b0, 8'h00, 16'h08FF);
        rows[13] = mk(OPC_LONG_JUMP, 8'h1D, 8'hFF, 16'h0000, K_FULL, 1'b0, 1'b0, 8'h00, 16'h1DFF);
        rows[14] = mk(OPC_LONG_CALL, 8'h1E, 8'h00, 16'h0000, K_FULL, 1'b0, 1'b0, 8'h00, 16'h1E00);
        rows[15] = mk(OPC_NO_OP, 8'h00, 8'h00, 16'h0456, K_NOP, 1'b0, 1'b0, 8'h00, 16'h0000);
        rows[16] = mk(OPC_UNUSED, 8'h12, 8'h34, 16'h0456, K_NOP, 1'b0, 1'b0, 8'h00, 16'h0000);
        rows[17] = mk(OPC_DEC_DIR_JP, 8'h90, 8'hFE, 16'h0300, K_REL, 1'b0, 1'b1, 8'h90, 16'h02FE);
        rows[18] = mk(8'hDA, 8'h10, 8'h00, 16'h0400, K_REL, 1'b1, 1'b0, 8'h12, 16'h0410);
        repeat (3) @(negedge core_clk);
        check(64'({reg_rdata_q, dec_ready_q, dec_res_q, ram_rd_q, ram_addr_q}), 64'({8'h00, 1'b1, 33'h0, 9'h0}));
        repeat (9) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_chk(STATUS_OFS, STATUS_RESET);
        @(posedge core_clk);
        accumulator <= 8'h01;
        reg_write(STATUS_OFS, 8'hFF, 1'b0, 1'b0);
        rd_chk(STATUS_OFS, 8'hFF);
        @(posedge core_clk);
        accumulator <= 8'h03;
        rd_chk(STATUS_OFS, 8'hFE);
        reg_write(8'h01, 8'h5A, 1'b0, 1'b0);
        rd_chk(8'h01, 8'h00);
        rd_chk(STATUS_OFS, 8'hFE);
        alu_event(1'b0);
        rd_chk(STATUS_OFS, 8'h7E);
        alu_event(1'b1);
        rd_chk(STATUS_OFS, 8'hFE);
        reg_write(STATUS_OFS, 8'h00, 1'b1, 1'b1);
        rd_chk(STATUS_OFS, CARRY_MASK);
        @(posedge core_clk);
        accumulator <= 8'h00;
        reg_write(STATUS_OFS, 8'h10, 1'b0, 1'b0);
        for (int i = 0; i <= 19; i++) begin
            @(posedge core_clk);
            if (i < 19) begin
                dec_req   <= rows[i].req;
                dec_valid <= 1'b1;
            end else begin
                dec_valid <= 1'b0;
            end
            @(negedge core_clk);
            if (i > 0) begin
                check(64'(dec_res_q), 64'(rows[i - 1].exp));
            end
        end
        indirect(2'h1, 1'b1);
        indirect(2'h3, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
